// File: rtl/sfp_pin_if.sv
`timescale 1ns/1ps
`default_nettype none

module sfp_pin_if (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic cs_b_in,
    input wire logic sck_in,
    input wire logic si_in,
    output logic so_out,
    output logic so_oe_out,
    input wire logic wg_in,
    output logic wg_out,
    output logic wg_oe_out,
    input wire logic pause_b_in,
    output logic standby_out
);
    import sfp_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisation and edge detection
    // ----------------------------------------------------------------
    sfp_pins_t pins_raw;
    sfp_pins_t pins_s;
    logic sel_d_ff;
    logic sck_d_ff;
    logic pause_d_ff;

    assign pins_raw = '{pause_b: pause_b_in, wg: wg_in, si: si_in, sck: sck_in, cs_b: cs_b_in};

    sfp_sync #(.W(SYNC_W), .RST_VAL(PINS_RESET)) u_sync (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .d_in(pins_raw),
        .q_out(pins_s)
    );

    wire sel = ~pins_s.cs_b;
    wire frame_start = sel & ~sel_d_ff;
    wire frame_end = ~sel & sel_d_ff;
    wire sck_rise = pins_s.sck & ~sck_d_ff;
    wire sck_fall = ~pins_s.sck & sck_d_ff;
    wire pause_fall = ~pins_s.pause_b & pause_d_ff;
    wire pause_rise = pins_s.pause_b & ~pause_d_ff;

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    sfp_ctrl_t ctrl_ff;
    sfp_cfg_t cfg_ff;
    logic [7:0] tx_data_ff;
    logic [7:0] rx_data_ff;
    logic rx_valid_ff;
    logic blocked_ff;
    logic hold_ff;
    logic [6:0] rx_sh_ff;
    logic [2:0] bit_cnt_ff;
    logic [7:0] tx_sh_ff;
    logic pending_ff;
    logic l2_smp_ff;
    logic [7:0] busy_cnt_ff;
    logic so_ff;
    logic so_oe_ff;
    logic wg_ff;
    logic wg_oe_ff;
    logic standby_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;

    // hold only exists while selected and the pin is not a quad line
    wire hold_on = sel & ~cfg_ff.qe & pause_fall & ~pins_s.sck;
    wire hold_off = pause_rise & ~pins_s.sck;
    wire nxt_hold = (~sel | cfg_ff.qe) ? 1'b0 : (hold_on | (hold_ff & ~hold_off));

    // clock edges count only inside a frame and outside hold
    wire act_rise = sel & ~hold_ff & sck_rise;
    wire act_fall = sel & ~hold_ff & sck_fall & ~frame_start;
    wire launch = act_fall & pending_ff;
    wire byte_done = act_rise & (bit_cnt_ff == 3'h7);
    wire busy = busy_cnt_ff != 8'h00;
    wire blocked = ~cfg_ff.qe & ~cfg_ff.sph & cfg_ff.spl & ~pins_s.wg;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire apb_setup = psel_in & ~penable_in;
    wire apb_acc = psel_in & penable_in & pready_ff;
    wire apb_wr = apb_acc & pwrite_in;
    wire hit_ctrl = paddr_in == ADDR_CTRL;
    wire hit_cfg = paddr_in == ADDR_CFG;
    wire hit_tx = paddr_in == ADDR_TXDATA;
    wire hit_rx = paddr_in == ADDR_RXDATA;
    wire hit_st = paddr_in == ADDR_STATUS;
    wire mapped = hit_ctrl | hit_cfg | hit_tx | hit_rx | hit_st;
    wire wr_ctrl = apb_wr & hit_ctrl;
    wire wr_cfg = apb_wr & hit_cfg;
    wire wr_st = apb_wr & hit_st;

    logic [31:0] status_word;
    always_comb
    begin
        status_word = '0;
        status_word[ST_SELECTED_BIT] = sel;
        status_word[ST_BUSY_BIT] = busy;
        status_word[ST_HOLD_BIT] = hold_ff;
        status_word[ST_RX_VALID_BIT] = rx_valid_ff;
        status_word[ST_BLOCKED_BIT] = blocked_ff;
        status_word[ST_WG_LEVEL_BIT] = pins_s.wg;
        status_word[ST_L2_SAMPLE_BIT] = l2_smp_ff;
    end

    wire [31:0] rdata_mux = hit_ctrl ? {29'h0, ctrl_ff} :
                            hit_cfg ? {29'h0, cfg_ff} :
                            hit_tx ? {24'h0, tx_data_ff} :
                            hit_rx ? {24'h0, rx_data_ff} :
                            hit_st ? status_word : 32'h0;

    // ----------------------------------------------------------------
    // next values of register fields
    // ----------------------------------------------------------------
    // a write to the status config while guarded is dropped and flagged
    wire cfg_take = wr_cfg & ~blocked;
    wire blk_event = wr_cfg & blocked;
    // software write of arm wins; otherwise hardware clears it when the timed op starts
    wire timed_start = frame_end & ctrl_ff.arm;
    sfp_ctrl_t nxt_ctrl;
    assign nxt_ctrl = wr_ctrl ? sfp_ctrl_t'(pwdata_in[2:0]) :
                      timed_start ? sfp_ctrl_t'({ctrl_ff.l2_level, ctrl_ff.l2_drive, 1'b0}) :
                      ctrl_ff;
    // sticky flags: the setting event wins over a write-one-to-clear
    wire nxt_rx_valid = byte_done | (rx_valid_ff & ~(wr_st & pwdata_in[ST_RX_VALID_BIT]));
    wire nxt_blocked = blk_event | (blocked_ff & ~(wr_st & pwdata_in[ST_BLOCKED_BIT]));
    wire [7:0] nxt_busy_cnt = timed_start ? OP_CYCLES : (busy ? busy_cnt_ff - 8'h01 : 8'h00);

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
            ctrl_ff <= CTRL_RESET;
            cfg_ff <= CFG_RESET;
            tx_data_ff <= TXDATA_RESET;
        end
        else
        begin
            pready_ff <= apb_setup;
            pslverr_ff <= apb_setup & ~mapped;
            prdata_ff <= (apb_setup & ~pwrite_in) ? rdata_mux : 32'h0;
            ctrl_ff <= nxt_ctrl;
            if (cfg_take)
                cfg_ff <= sfp_cfg_t'(pwdata_in[2:0]);
            if (apb_wr & hit_tx)
                tx_data_ff <= pwdata_in[7:0];
        end
    end

    // ----------------------------------------------------------------
    // frame, hold and busy tracking
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sel_d_ff <= 1'b0;
            sck_d_ff <= 1'b0;
            pause_d_ff <= 1'b1;
            hold_ff <= 1'b0;
            rx_valid_ff <= 1'b0;
            blocked_ff <= 1'b0;
            busy_cnt_ff <= 8'h00;
            standby_ff <= 1'b1;
        end
        else
        begin
            sel_d_ff <= sel;
            sck_d_ff <= pins_s.sck;
            pause_d_ff <= pins_s.pause_b;
            hold_ff <= nxt_hold;
            rx_valid_ff <= nxt_rx_valid;
            blocked_ff <= nxt_blocked;
            busy_cnt_ff <= nxt_busy_cnt;
            standby_ff <= ~sel & ~busy & ~timed_start;
        end
    end

    // ----------------------------------------------------------------
    // shift paths
    // ----------------------------------------------------------------
    logic [7:0] nxt_tx_sh;
    logic nxt_so;
    always_comb
    begin
        nxt_tx_sh = tx_sh_ff;
        nxt_so = so_ff;
        if (frame_start)
        begin
            nxt_tx_sh = tx_data_ff;
            nxt_so = tx_data_ff[7];
        end
        else if (launch)
        begin
            // a wrapped counter means the byte is out: reload for the next one
            if (bit_cnt_ff == 3'h0)
            begin
                nxt_tx_sh = tx_data_ff;
                nxt_so = tx_data_ff[7];
            end
            else
            begin
                nxt_tx_sh = {tx_sh_ff[6:0], 1'b0};
                nxt_so = tx_sh_ff[6];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_sh_ff <= 7'h00;
            bit_cnt_ff <= 3'h0;
            rx_data_ff <= 8'h00;
            l2_smp_ff <= 1'b0;
            pending_ff <= 1'b0;
            tx_sh_ff <= 8'h00;
            so_ff <= 1'b0;
        end
        else
        begin
            if (frame_start)
                bit_cnt_ff <= 3'h0;
            else if (act_rise)
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (act_rise)
                rx_sh_ff <= {rx_sh_ff[5:0], pins_s.si};
            if (byte_done)
                rx_data_ff <= {rx_sh_ff, pins_s.si};
            if (act_rise & cfg_ff.qe)
                l2_smp_ff <= pins_s.wg;
            pending_ff <= frame_start ? 1'b0 : (act_rise | (pending_ff & ~launch));
            tx_sh_ff <= nxt_tx_sh;
            so_ff <= nxt_so;
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    // enables follow the synchronised select, so they trail the pin by three clocks
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            so_oe_ff <= 1'b0;
            wg_oe_ff <= 1'b0;
            wg_ff <= 1'b0;
        end
        else
        begin
            so_oe_ff <= sel & ~hold_ff;
            wg_oe_ff <= sel & ~hold_ff & cfg_ff.qe & ctrl_ff.l2_drive;
            if (frame_start | launch)
                wg_ff <= ctrl_ff.l2_level;
        end
    end

    assign prdata_out = prdata_ff;
    assign pready_out = pready_ff;
    assign pslverr_out = pslverr_ff;
    assign so_out = so_ff;
    assign so_oe_out = so_oe_ff;
    assign wg_out = wg_ff;
    assign wg_oe_out = wg_oe_ff;
    assign standby_out = standby_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_b_in);

    AST_SEL_NOT_STANDBY: assert property (sel |=> !standby_out)
        else $error("standby while selected");
    AST_SO_HIZ: assert property (!sel |=> !so_oe_out)
        else $error("output driven while deselected");
    AST_NO_CAPTURE: assert property (!sel |=> $stable(rx_sh_ff) && $stable(rx_data_ff))
        else $error("capture while deselected");
    AST_FRAME_START: assert property (frame_start |=> bit_cnt_ff == 3'h0 && !pending_ff)
        else $error("frame start did not reset the bit count");
    AST_FRAME_END: assert property (frame_end |=> !so_oe_out && !wg_oe_out)
        else $error("pins still driven after frame end");
    AST_TIMED_BUSY: assert property (timed_start |=> busy_cnt_ff == OP_CYCLES ##1 !standby_out [*3])
        else $error("standby entered before timed operation finished");
    AST_SAMPLE_RISE: assert property (act_rise |=> rx_sh_ff[0] == $past(pins_s.si))
        else $error("serial input not sampled on rising edge");
    AST_LAUNCH_FALL: assert property ($changed(so_out) |-> $past(launch || frame_start))
        else $error("output changed outside a falling edge");
    AST_GUARD: assert property (wr_cfg && blocked |=> $stable(cfg_ff) && blocked_ff)
        else $error("guarded status config was modified");
    AST_QUAD_LINE: assert property (wg_oe_out |-> $past(cfg_ff.qe && sel))
        else $error("line two driven without quad enable");
    AST_HOLD: assert property (hold_ff && sck_rise |=> $stable(bit_cnt_ff))
        else $error("clock counted during hold");
    AST_MODE3: assert property (act_fall && !pending_ff |=> $stable(tx_sh_ff))
        else $error("launch without a preceding rising edge");

    COV_BYTE: cover property (byte_done);
    COV_TIMED: cover property (timed_start ##[1:300] standby_out);
    COV_HOLD: cover property (hold_on ##[1:200] hold_off);
    COV_BLOCKED: cover property (blk_event);
endmodule

`default_nettype wire

// File: rtl/sfp_pkg.sv
package sfp_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_RXDATA = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_ARM_BIT = 0;
    localparam int CTRL_L2_DRIVE_BIT = 1;
    localparam int CTRL_L2_LEVEL_BIT = 2;
    localparam int CFG_QE_BIT = 0;
    localparam int CFG_SPH_BIT = 1;
    localparam int CFG_SPL_BIT = 2;
    localparam int ST_SELECTED_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_HOLD_BIT = 2;
    localparam int ST_RX_VALID_BIT = 3;
    localparam int ST_BLOCKED_BIT = 4;
    localparam int ST_WG_LEVEL_BIT = 5;
    localparam int ST_L2_SAMPLE_BIT = 6;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam logic [7:0] TXDATA_RESET = 8'hff;
    // idle pin levels (pause_b, wg, si, sck, cs_b) so no false edge follows reset
    localparam logic [4:0] PINS_RESET = 5'h19;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int OP_TIME_NS = 1000;
    localparam int OP_CYCLES_INT = (OP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] OP_CYCLES = 8'(OP_CYCLES_INT);
    localparam int SYNC_W = 5;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic pause_b;
        logic wg;
        logic si;
        logic sck;
        logic cs_b;
    } sfp_pins_t;

    typedef struct packed {
        logic spl;
        logic sph;
        logic qe;
    } sfp_cfg_t;

    typedef struct packed {
        logic l2_level;
        logic l2_drive;
        logic arm;
    } sfp_ctrl_t;

endpackage

// File: rtl/sfp_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser; only the second stage is visible
module sfp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            meta_ff <= RST_VAL;
            q_ff <= RST_VAL;
        end
        else
        begin
            meta_ff <= d_in;
            q_ff <= meta_ff;
        end
    end

    assign q_out = q_ff;
endmodule

`default_nettype wire

// File: verif/sfp_host.sv
`timescale 1ns/1ps
`default_nettype none

module sfp_host (
    input wire logic so_in,
    output logic cs_b_out,
    output logic sck_out,
    output logic si_out,
    output logic pause_b_out,
    output logic wg_out,
    output logic wg_oe_out
);
    // -----------------------------
    // link timing, 64 ns clock
    // -----------------------------
    localparam int HALF = 32;
    logic idle_lvl;

    initial
    begin
        idle_lvl = 1'b0;
        cs_b_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
        pause_b_out = 1'b1;
        wg_out = 1'b1;
        wg_oe_out = 1'b0;
    end

    // odd offset keeps the link edges away from the system clock phase
    task automatic select(input logic mode3);
        idle_lvl = mode3;
        sck_out = mode3;
        #(2 * HALF + 1);
        cs_b_out = 1'b0;
        #HALF;
    endtask

    // data line is flipped once released so a stale bit never looks valid
    task automatic deselect();
        #HALF;
        cs_b_out = 1'b1;
        si_out = ~si_out;
        #(2 * HALF);
    endtask

    // output is taken at the end of the low half, just before the rise
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--)
        begin
            sck_out = 1'b0;
            si_out = tx[i];
            #HALF;
            rx[i] = so_in;
            sck_out = 1'b1;
            #HALF;
        end
        sck_out = idle_lvl;
        si_out = ~si_out;
        #HALF;
    endtask

    task automatic noise();
        repeat (8)
        begin
            sck_out = ~sck_out;
            si_out = ~si_out;
            #HALF;
        end
    endtask

    task automatic pause(input logic lvl);
        pause_b_out = lvl;
        #(2 * HALF);
    endtask

    task automatic guard(input logic oe, input logic lvl);
        wg_oe_out = oe;
        wg_out = oe ? lvl : ~wg_out;
        #(2 * HALF);
    endtask
endmodule

`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import sfp_pkg::*;
    localparam logic [31:0] ALL = 32'hffffffff;
    logic mclk_in;
    logic rst_b_in;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready, pslverr, cs_b, sck, si, so, so_oe, pause_b, standby;
    logic wg_o, wg_oe, h_wg, h_wg_oe, wg_wire;
    int num_errors = 0;
    int n_tests = 0;
    logic [31:0] q;
    logic e;
    logic [7:0] rx;

    always #2.5 mclk_in = ~mclk_in;
    // the guard pin has an internal pull-up when nobody drives it
    assign wg_wire = wg_oe ? wg_o : (h_wg_oe ? h_wg : 1'b1);

    sfp_pin_if sfp_pin_if_inst (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .cs_b_in(cs_b), .sck_in(sck),
        .si_in(si), .so_out(so), .so_oe_out(so_oe), .wg_in(wg_wire), .wg_out(wg_o),
        .wg_oe_out(wg_oe), .pause_b_in(pause_b), .standby_out(standby)
    );
    sfp_host sfp_host_inst (
        .so_in(so), .cs_b_out(cs_b), .sck_out(sck), .si_out(si),
        .pause_b_out(pause_b), .wg_out(h_wg), .wg_oe_out(h_wg_oe)
    );

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    // the answer is taken at the very edge that samples pready high, then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        @(posedge mclk_in);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge mclk_in);
            n++;
        end
        if (n == 20)
        begin
            num_errors++;
            report_and_stop();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q & m, x);
    endtask

    task automatic t_reset();
        @(negedge mclk_in);
        chk(32'(standby), 32'h1);
        chk(32'(so_oe), 32'h0);
        rdm(ADDR_CTRL, ALL, 32'h0);
        rdm(ADDR_CFG, ALL, 32'h0);
        rdm(ADDR_TXDATA, ALL, 32'hff);
        rdm(ADDR_STATUS, 32'h7f, 32'h20);
        apb(1'b0, 8'h14, 32'h0);
        chk(32'(e), 32'h1);
        wr(ADDR_RXDATA, 32'h55);
        rdm(ADDR_RXDATA, ALL, 32'h0);
        sfp_host_inst.noise();
        rdm(ADDR_RXDATA, ALL, 32'h0);
        rdm(ADDR_STATUS, 32'h0b, 32'h0);
        $display("test reset and deselected done");
    endtask

    task automatic t_mode0();
        wr(ADDR_TXDATA, 32'ha5);
        sfp_host_inst.select(1'b0);
        @(negedge mclk_in);
        chk(32'(standby), 32'h0);
        chk(32'(so_oe), 32'h1);
        rdm(ADDR_STATUS, 32'h1, 32'h1);
        sfp_host_inst.xfer(8'h3c, 8, rx);
        chk(32'(rx), 32'ha5);
        sfp_host_inst.deselect();
        @(negedge mclk_in);
        chk(32'(so_oe), 32'h0);
        chk(32'(standby), 32'h1);
        rdm(ADDR_RXDATA, ALL, 32'h3c);
        rdm(ADDR_STATUS, 32'h9, 32'h8);
        wr(ADDR_STATUS, 32'h8);
        rdm(ADDR_STATUS, 32'h8, 32'h0);
        $display("test mode 0 frame done");
    endtask

    task automatic t_mode3();
        wr(ADDR_TXDATA, 32'h5a);
        sfp_host_inst.select(1'b1);
        sfp_host_inst.xfer(8'hf0, 4, rx);
        chk(32'(rx), 32'h50);
        sfp_host_inst.deselect();
        sfp_host_inst.select(1'b1);
        sfp_host_inst.xfer(8'h81, 8, rx);
        chk(32'(rx), 32'h5a);
        sfp_host_inst.deselect();
        rdm(ADDR_RXDATA, ALL, 32'h81);
        $display("test mode 3 restart done");
    endtask

    task automatic t_hold();
        sfp_host_inst.select(1'b0);
        sfp_host_inst.xfer(8'h90, 4, rx);
        sfp_host_inst.pause(1'b0);
        @(negedge mclk_in);
        chk(32'(so_oe), 32'h0);
        rdm(ADDR_STATUS, 32'h4, 32'h4);
        sfp_host_inst.noise();
        sfp_host_inst.pause(1'b1);
        @(negedge mclk_in);
        chk(32'(so_oe), 32'h1);
        sfp_host_inst.xfer(8'h60, 4, rx);
        chk(32'(rx), 32'ha0);
        sfp_host_inst.deselect();
        rdm(ADDR_RXDATA, ALL, 32'h96);
        $display("test hold done");
    endtask

    task automatic t_timed();
        int n;
        n = 0;
        wr(ADDR_CTRL, 32'h1);
        sfp_host_inst.select(1'b0);
        sfp_host_inst.xfer(8'h02, 8, rx);
        sfp_host_inst.deselect();
        rdm(ADDR_STATUS, 32'h3, 32'h2);
        @(negedge mclk_in);
        chk(32'(standby), 32'h0);
        while (standby !== 1'b1 && n < 400)
        begin
            @(negedge mclk_in);
            n++;
        end
        if (n == 400)
        begin
            num_errors++;
            report_and_stop();
        end
        chk(32'(n > OP_CYCLES_INT - 50 && n < OP_CYCLES_INT), 32'h1);
        rdm(ADDR_CTRL, 32'h1, 32'h0);
        $display("test timed operation done");
    endtask

    task automatic t_guard();
        wr(ADDR_CFG, 32'h4);
        rdm(ADDR_CFG, ALL, 32'h4);
        sfp_host_inst.guard(1'b1, 1'b0);
        wr(ADDR_CFG, 32'h6);
        rdm(ADDR_CFG, ALL, 32'h4);
        rdm(ADDR_STATUS, 32'h30, 32'h10);
        wr(ADDR_STATUS, 32'h10);
        sfp_host_inst.guard(1'b0, 1'b1);
        wr(ADDR_CFG, 32'h5);
        wr(ADDR_CTRL, 32'h6);
        // line two is only driven inside a frame
        sfp_host_inst.select(1'b0);
        @(negedge mclk_in);
        chk(32'({wg_oe, wg_o}), 32'h3);
        wr(ADDR_CTRL, 32'h2);
        sfp_host_inst.xfer(8'h80, 1, rx);
        rdm(ADDR_STATUS, 32'h40, 32'h40);
        wr(ADDR_CFG, 32'h7);
        rdm(ADDR_CFG, ALL, 32'h7);
        chk(32'({wg_oe, wg_o}), 32'h2);
        wr(ADDR_CFG, 32'h0);
        repeat (2) @(negedge mclk_in);
        chk(32'(wg_oe), 32'h0);
        sfp_host_inst.deselect();
        $display("test guard and quad line done");
    endtask

    initial
    begin
        mclk_in = 1'b0;
        rst_b_in = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        t_reset();
        t_mode0();
        t_mode3();
        t_hold();
        t_timed();
        t_guard();
        report_and_stop();
    end
endmodule

`default_nettype wire
